// ===== logic/sfc_regs.vh
// constants for the stacked flash host controller
`ifndef SFC_REGS_VH
`define SFC_REGS_VH
// ---------------------------------------------------------------
// register offsets (controller's own command port)
// ---------------------------------------------------------------
`define SFC_ADDR_CTRL      4'h0
`define SFC_ADDR_ADDR      4'h1
`define SFC_ADDR_WDATA     4'h2
`define SFC_ADDR_CMD       4'h3
`define SFC_ADDR_STATUS    4'h4
`define SFC_ADDR_RDATA     4'h5
`define SFC_ADDR_RDY_EVT   4'h6
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SFC_CTRL_WORD      0
`define SFC_CTRL_PROTECT   1
`define SFC_CMD_WRITE      0
`define SFC_CMD_READ       1
`define SFC_CMD_RESET      2
`define SFC_ST_BUSY        0
`define SFC_ST_PIN_LOW     1
`define SFC_ST_RECOVER     2
`define SFC_ST_DONE        3
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SFC_CTRL_RST       2'h0
// ---------------------------------------------------------------
// timing, in ns and derived 50 MHz cycles
// ---------------------------------------------------------------
`define SFC_CLK_PERIOD_NS  20
`define SFC_RST_PULSE_NS   10000
`define SFC_RST_RECOV_NS   50000
`define SFC_ACCESS_NS      110
`define SFC_SETUP_NS       70
`define SFC_CEIL_CYC(ns)   (((ns) + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS)
`endif

// ===== logic/sfc_rdata_mem.v
// small register file holding the last word read from the flash
module sfc_rdata_mem #(
   parameter AW = 2,
   parameter DW = 16
) (
   input  wire          core_clk_in,
   input  wire          wr_en_in,
   input  wire [AW-1:0] wr_addr_in,
   input  wire [DW-1:0] wr_data_in,
   input  wire [AW-1:0] rd_addr_in,
   output reg  [DW-1:0] rd_data_out
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge core_clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule // sfc_rdata_mem

// ===== logic/sfc_host.v
// host controller driving the stacked flash pin interface
// What this block does
// - hold reset low for minimum pulse time
// - wait recovery time before first access
// - drive device reset from system reset
// - drive protect from the CTRL protect bit, low from reset
// - keep output enable high during writes
`include "sfc_regs.vh"
module sfc_host #(
   parameter AW          = 24,
   parameter DW          = 16,
   parameter RST_PULSE_CYC = `SFC_CEIL_CYC(`SFC_RST_PULSE_NS),
   parameter RST_RECOV_CYC = `SFC_CEIL_CYC(`SFC_RST_RECOV_NS)
) (
   input  wire          core_clk_in,
   input  wire          nrst_in,
   input  wire [3:0]    reg_addr_in,
   input  wire [31:0]   reg_wdata_in,
   input  wire          reg_wr_in,
   input  wire          reg_rd_in,
   output reg  [31:0]   reg_rdata_out,
   output reg  [AW-1:0] flash_addr_out,
   input  wire [DW-1:0] data_io_in,
   output reg  [DW-1:0] data_io_out,
   output reg           data_io_oe_out,
   output reg           chip_sel_n_out,
   output reg           out_en_n_out,
   output reg           wr_en_n_out,
   output reg           reset_powerdown_n_out,
   output reg           word_width_out,
   output reg           program_erase_protect_out,
   input  wire          pe_status_pin_in
);
   localparam ACC_CYC = `SFC_CEIL_CYC(`SFC_ACCESS_NS);
   localparam SET_CYC = `SFC_CEIL_CYC(`SFC_SETUP_NS);
   localparam CW      = 20;
   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam S_IDLE  = 6'h01;
   localparam S_WR    = 6'h02;
   localparam S_RD    = 6'h04;
   localparam S_RST   = 6'h08;
   localparam S_RECOV = 6'h10;
   localparam S_HOLD  = 6'h20;

   function [CW-1:0] sfc_cyc;
      input integer n;
      begin
         sfc_cyc = n[CW-1:0];
      end
   endfunction

   reg [5:0]    state_r;
   reg [CW-1:0] cnt_r;
   reg [1:0]    ctrl_r;
   reg [AW-1:0] addr_r;
   reg [DW-1:0] wdata_r;
   reg          done_r;
   reg          pin_d_r;
   reg          rdy_evt_r;
   // capture at the edge that deselects: one cycle later the bus is already released
   wire         mem_we = (state_r == S_RD) && (cnt_r == sfc_cyc(ACC_CYC));
   wire [DW-1:0] mem_q;

   sfc_rdata_mem #(.AW(2), .DW(DW)) u_mem (
      .core_clk_in (core_clk_in),
      .wr_en_in    (mem_we),
      .wr_addr_in  (2'h0),
      .wr_data_in  (data_io_in),
      .rd_addr_in  (2'h0),
      .rd_data_out (mem_q)
   );

   wire cmd_go = reg_wr_in && (reg_addr_in == `SFC_ADDR_CMD);
   wire busy   = (state_r != S_IDLE);

   // ---------------------------------------------------------------
   // pin sequencer
   // ---------------------------------------------------------------
   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         // system reset also drives the device reset
         state_r                   <= S_RST;
         cnt_r                     <= {CW{1'b0}};
         ctrl_r                    <= `SFC_CTRL_RST;
         addr_r                    <= {AW{1'b0}};
         wdata_r                   <= {DW{1'b0}};
         done_r                    <= 1'b0;
         flash_addr_out            <= {AW{1'b0}};
         data_io_out               <= {DW{1'b0}};
         data_io_oe_out            <= 1'b0;
         chip_sel_n_out            <= 1'b1;
         out_en_n_out              <= 1'b1;
         wr_en_n_out               <= 1'b1;
         reset_powerdown_n_out     <= 1'b0;
         word_width_out            <= 1'b0;
         program_erase_protect_out <= 1'b0;
      end else begin
         word_width_out            <= ctrl_r[`SFC_CTRL_WORD];
         program_erase_protect_out <= ctrl_r[`SFC_CTRL_PROTECT];
         if (reg_wr_in && reg_addr_in == `SFC_ADDR_CTRL)
            ctrl_r <= reg_wdata_in[1:0];
         if (reg_wr_in && reg_addr_in == `SFC_ADDR_ADDR && !busy)
            addr_r <= reg_wdata_in[AW-1:0];
         if (reg_wr_in && reg_addr_in == `SFC_ADDR_WDATA && !busy)
            wdata_r <= reg_wdata_in[DW-1:0];
         case (state_r)
            S_IDLE: begin
               cnt_r <= {CW{1'b0}};
               if (cmd_go && reg_wdata_in[`SFC_CMD_RESET]) begin
                  state_r               <= S_RST;
                  reset_powerdown_n_out <= 1'b0;
               end else if (cmd_go && reg_wdata_in[`SFC_CMD_WRITE]) begin
                  done_r         <= 1'b0;
                  state_r        <= S_WR;
                  flash_addr_out <= addr_r;
                  data_io_out    <= wdata_r;
                  data_io_oe_out <= 1'b1;
                  out_en_n_out   <= 1'b1;
                  chip_sel_n_out <= 1'b0;
                  wr_en_n_out    <= 1'b0;
               end else if (cmd_go && reg_wdata_in[`SFC_CMD_READ]) begin
                  done_r         <= 1'b0;
                  state_r        <= S_RD;
                  flash_addr_out <= addr_r;
                  data_io_oe_out <= 1'b0;
                  chip_sel_n_out <= 1'b0;
                  out_en_n_out   <= 1'b0;
               end
            end
            S_WR: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == sfc_cyc(SET_CYC - 1)) begin
                  // write enable rises first; address and data still held
                  wr_en_n_out <= 1'b1;
                  cnt_r       <= {CW{1'b0}};
                  state_r     <= S_HOLD;
               end
            end
            S_HOLD: begin
               // one cycle of hold before releasing select and data
               chip_sel_n_out <= 1'b1;
               data_io_oe_out <= 1'b0;
               done_r         <= 1'b1;
               state_r        <= S_IDLE;
            end
            S_RD: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == sfc_cyc(ACC_CYC)) begin
                  chip_sel_n_out <= 1'b1;
                  out_en_n_out   <= 1'b1;
                  done_r         <= 1'b1;
                  cnt_r          <= {CW{1'b0}};
                  state_r        <= S_IDLE;
               end
            end
            S_RST: begin
               reset_powerdown_n_out <= 1'b0;
               chip_sel_n_out        <= 1'b1;
               out_en_n_out          <= 1'b1;
               wr_en_n_out           <= 1'b1;
               data_io_oe_out        <= 1'b0;
               cnt_r                 <= cnt_r + 1'b1;
               if (cnt_r == sfc_cyc(RST_PULSE_CYC - 1)) begin
                  reset_powerdown_n_out <= 1'b1;
                  cnt_r                 <= {CW{1'b0}};
                  state_r               <= S_RECOV;
               end
            end
            S_RECOV: begin
               // device comes back in array read; no access until recovered
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == sfc_cyc(RST_RECOV_CYC - 1)) begin
                  cnt_r   <= {CW{1'b0}};
                  state_r <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // status pin watcher: sticky event on a release or a pulse
   // ---------------------------------------------------------------
   wire evt_clr = reg_wr_in && (reg_addr_in == `SFC_ADDR_RDY_EVT) && reg_wdata_in[0];
   wire evt_set = pe_status_pin_in && !pin_d_r;

   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         pin_d_r   <= 1'b1;
         rdy_evt_r <= 1'b0;
      end else begin
         pin_d_r <= pe_status_pin_in;
         if (evt_set)
            rdy_evt_r <= 1'b1;
         else if (evt_clr)
            rdy_evt_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------
   always @(posedge core_clk_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `SFC_ADDR_CTRL:    reg_rdata_out <= {30'h0, ctrl_r};
            `SFC_ADDR_ADDR:    reg_rdata_out <= {{(32-AW){1'b0}}, addr_r};
            `SFC_ADDR_WDATA:   reg_rdata_out <= {{(32-DW){1'b0}}, wdata_r};
            `SFC_ADDR_STATUS:  reg_rdata_out <= {28'h0, done_r,
                                                 state_r == S_RECOV,
                                                 ~pe_status_pin_in, busy};
            `SFC_ADDR_RDATA:   reg_rdata_out <= {{(32-DW){1'b0}}, mem_q};
            `SFC_ADDR_RDY_EVT: reg_rdata_out <= {31'h0, rdy_evt_r};
            default:           reg_rdata_out <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_out <= 32'h0000_0000;
      end
   end
endmodule // sfc_host

// ===== testbench/sfc_host_sva.sv
// pin timing checker for the stacked flash host controller
module sfc_host_chk #(
   parameter AW = 24,
   parameter DW = 16,
   parameter RST_PULSE_CYC = 500,
   parameter RST_RECOV_CYC = 2500
) (
   input wire          core_clk_in,
   input wire          nrst_in,
   input wire [AW-1:0] flash_addr_out,
   input wire [DW-1:0] data_io_out,
   input wire          data_io_oe_out,
   input wire          chip_sel_n_out,
   input wire          out_en_n_out,
   input wire          wr_en_n_out,
   input wire          reset_powerdown_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   int lo_cnt_r = 0;
   int hi_cnt_r = 0;
   // counters free of nrst: the pulse length includes the system reset time
   always @(posedge core_clk_in) begin
      if (reset_powerdown_n_out) begin
         lo_cnt_r <= 0;
         hi_cnt_r <= hi_cnt_r + 1;
      end else begin
         lo_cnt_r <= lo_cnt_r + 1;
         hi_cnt_r <= 0;
      end
   end
   sequence s_we_low;
      (!wr_en_n_out) [*4];
   endsequence
   sequence s_we_end;
      wr_en_n_out && !chip_sel_n_out && data_io_oe_out;
   endsequence
   a_rst_pulse_len: assert property ($rose(reset_powerdown_n_out) |-> lo_cnt_r >= RST_PULSE_CYC)
      else $error("reset pulse too short");
   a_rst_follow: assert property ($rose(nrst_in) |-> !reset_powerdown_n_out)
      else $error("device reset not held with system reset");
   a_recov_wait: assert property ($fell(chip_sel_n_out) |-> hi_cnt_r >= RST_RECOV_CYC)
      else $error("access before recovery time");
   a_idle_reset: assert property (!reset_powerdown_n_out |-> chip_sel_n_out && wr_en_n_out)
      else $error("bus active during device reset");
   a_oe_in_write: assert property (!wr_en_n_out |-> out_en_n_out && !chip_sel_n_out)
      else $error("output enable low during write");
   a_no_clash: assert property (data_io_oe_out |-> out_en_n_out)
      else $error("data driven while device output enabled");
   a_we_pulse: assert property ($fell(wr_en_n_out) |-> s_we_low ##1 s_we_end)
      else $error("write pulse shape wrong");
   a_we_hold: assert property ($rose(wr_en_n_out) |-> $stable(flash_addr_out) && $stable(data_io_out))
      else $error("address or data moved before write end");
endmodule // sfc_host_chk
bind sfc_host sfc_host_chk #(.AW(AW), .DW(DW), .RST_PULSE_CYC(RST_PULSE_CYC),
   .RST_RECOV_CYC(RST_RECOV_CYC)) sfc_host_chk_inst (.core_clk_in(core_clk_in),
   .nrst_in(nrst_in), .flash_addr_out(flash_addr_out), .data_io_out(data_io_out),
   .data_io_oe_out(data_io_oe_out), .chip_sel_n_out(chip_sel_n_out),
   .out_en_n_out(out_en_n_out), .wr_en_n_out(wr_en_n_out),
   .reset_powerdown_n_out(reset_powerdown_n_out));

// ===== testbench/sfc_flash_model.sv
// behavioural model of the stacked flash device pins
module sfc_flash_model #(
   parameter PROG_NS = 2000,
   parameter [7:0] CMD_PROG = 8'h40,
   parameter [7:0] CMD_READ = 8'hff,
   parameter [7:0] CMD_CFG  = 8'hb8
) (
   input  wire [23:0] a_in,
   input  wire [15:0] d_in,
   input  wire        cs_n_in,
   input  wire        oe_n_in,
   input  wire        we_n_in,
   input  wire        rp_n_in,
   input  wire        w_in,
   input  wire        pe_in,
   output wire [15:0] d_out,
   output wire        d_oe_out,
   output wire        sts_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [int];
   logic busy = 0, abort = 0, st_mode = 0, pulse = 0, arm = 0, cfg = 0, rd_st = 0;
   int tok = 0;
   wire wr_act = !cs_n_in && !we_n_in;
   wire [23:0] wa = w_in ? {a_in[23:1], 1'b0} : a_in;
   function automatic logic [7:0] rb(int k);
      return mem.exists(k) ? mem[k] : 8'hff;
   endfunction
   // latched when the first of the two enables rises
   always @(negedge wr_act) if (rp_n_in === 1'b1) begin
      if (arm) begin
         arm = 0;
         if (pe_in) begin
            mem[wa] = d_in[7:0];
            if (w_in) mem[wa + 1] = d_in[15:8];
            busy = 1;
            tok++;
            fork begin
               automatic int t = tok;
               #PROG_NS;
               if (t == tok) begin
                  busy = 0;
                  pulse = st_mode;
                  #200 pulse = 0;
               end
            end join_none
         end
      end else if (cfg) begin
         cfg = 0;
         st_mode = d_in[0];
      end else if (d_in[7:0] == CMD_PROG) begin
         arm = 1;
         rd_st = 1;
      end else if (d_in[7:0] == CMD_READ) rd_st = 0;
      else if (d_in[7:0] == CMD_CFG) cfg = 1;
   end
   always @(negedge rp_n_in) begin
      abort = busy;
      busy = 0;
      tok++;
      {arm, cfg, rd_st, st_mode} = 4'h0;
   end
   always @(posedge rp_n_in) abort = 0;
   assign sts_oe_out = rp_n_in ? (st_mode ? pulse : busy) : abort;
   assign d_oe_out = rp_n_in && !cs_n_in && !oe_n_in;
   assign d_out = rd_st ? {8'h0, !busy, 7'h0} :
      w_in ? {rb(wa + 1), rb(wa)} : {8'h0, rb(wa)};
endmodule // sfc_flash_model

// ===== testbench/testbench.sv
// self-checking bench for the stacked flash host controller
`include "sfc_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, nrst = 0, rw = 0, rr = 0;
   logic [3:0] ra = 4'h0;
   logic [31:0] wd = 32'h0, q;
   logic [15:0] fpat = 16'h5a5a;
   wire [31:0] rdat;
   wire [23:0] fa;
   wire [15:0] hout, dout;
   wire hoe, cs_n, oe_n, we_n, rp_n, ww, pe, doe, soe;
   // released bus toggles so stale values never pass
   wire [15:0] dq = hoe ? hout : doe ? dout : fpat;
   wire sts = !soe;
   int num_errors = 0, samples_checked = 0, cyc = 0;
   sfc_host #(.RST_PULSE_CYC(4), .RST_RECOV_CYC(8)) sfc_host_inst (.core_clk_in(clk),
      .nrst_in(nrst), .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(rw), .reg_rd_in(rr),
      .reg_rdata_out(rdat), .flash_addr_out(fa), .data_io_in(dq), .data_io_out(hout),
      .data_io_oe_out(hoe), .chip_sel_n_out(cs_n), .out_en_n_out(oe_n), .wr_en_n_out(we_n),
      .reset_powerdown_n_out(rp_n), .word_width_out(ww), .program_erase_protect_out(pe),
      .pe_status_pin_in(sts));
   sfc_flash_model sfc_flash_model_inst (.a_in(fa), .d_in(dq), .cs_n_in(cs_n), .oe_n_in(oe_n),
      .we_n_in(we_n), .rp_n_in(rp_n), .w_in(ww), .pe_in(pe), .d_out(dout), .d_oe_out(doe),
      .sts_oe_out(soe));
   initial forever #10 clk = ~clk;
   task automatic test_done;
      if (num_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      fpat <= ~fpat;
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         test_done;
      end
   end
   task automatic chk(input string n, input [31:0] g, input [31:0] e);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input [3:0] a, input [31:0] d);
      @(posedge clk) begin ra <= a; wd <= d; rw <= 1'b1; end
      @(posedge clk) rw <= 1'b0;
   endtask
   task automatic rd(input [3:0] a);
      @(posedge clk) begin ra <= a; rr <= 1'b1; end
      @(posedge clk) rr <= 1'b0;
      @(posedge clk) q = rdat;
   endtask
   task automatic idle;
      for (int i = 0; i < 300; i++) begin
         rd(`SFC_ADDR_STATUS);
         if (q[`SFC_ST_BUSY] === 1'b0) return;
      end
      num_errors++;
      test_done;
   endtask
   task automatic fw(input [23:0] a, input [15:0] d);
      wr(`SFC_ADDR_ADDR, {8'h0, a});
      wr(`SFC_ADDR_WDATA, {16'h0, d});
      wr(`SFC_ADDR_CMD, 32'h1);
      idle;
   endtask
   task automatic fr(input [23:0] a);
      wr(`SFC_ADDR_ADDR, {8'h0, a});
      wr(`SFC_ADDR_CMD, 32'h2);
      idle;
      rd(`SFC_ADDR_RDATA);
   endtask
   task automatic prog(input [23:0] a, input [15:0] d, input b);
      fw(a, 16'h0040);
      fw(a, d);
      fr(a);
      chk("ready bit", q[7], !b);
      for (int i = 0; i < 100 && q[7] !== 1'b1; i++) fr(a);
      fw(a, 16'h00ff);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(`SFC_ADDR_STATUS);
      chk("busy in reset", q[0], 1);
      idle;
      wr(`SFC_ADDR_CTRL, 32'h3);
      wr(`SFC_ADDR_RDY_EVT, 32'h1);
      prog(24'h800004, 16'h1234, 1);
      rd(`SFC_ADDR_RDY_EVT);
      chk("ready event", q[0], 1);
      wr(`SFC_ADDR_RDY_EVT, 32'h1);
      rd(`SFC_ADDR_RDY_EVT);
      chk("event clear", q[0], 0);
      prog(24'h000004, 16'habcd, 1);
      fr(24'h800005);
      chk("upper word", q[15:0], 16'h1234);
      wr(`SFC_ADDR_CTRL, 32'h1);
      prog(24'h000004, 16'h0000, 0);
      fr(24'h000004);
      chk("lower word", q[15:0], 16'habcd);
      wr(`SFC_ADDR_CTRL, 32'h2);
      prog(24'h000011, 16'h005a, 1);
      wr(`SFC_ADDR_CTRL, 32'h3);
      fr(24'h000010);
      chk("byte lane", q[15:0], 16'h5aff);
      fw(24'h000030, 16'h00b8);
      fw(24'h000030, 16'h0001);
      wr(`SFC_ADDR_RDY_EVT, 32'h1);
      fw(24'h000030, 16'h0040);
      fw(24'h000030, 16'h2222);
      rd(`SFC_ADDR_STATUS);
      chk("pin in pulse mode", q[1], 0);
      repeat (120) @(posedge clk);
      rd(`SFC_ADDR_RDY_EVT);
      chk("pulse event", q[0], 1);
      fw(24'h000030, 16'h00ff);
      fw(24'h000020, 16'h0040);
      fw(24'h000020, 16'h1111);
      chk("write done", q[3:0], 4'h8);
      wr(`SFC_ADDR_CMD, 32'h4);
      rd(`SFC_ADDR_STATUS);
      chk("abort pin", q[1], 1);
      idle;
      fr(24'h800004);
      chk("array after reset", q[15:0], 16'h1234);
      wr(`SFC_ADDR_CMD, 32'h4);
      rd(`SFC_ADDR_STATUS);
      chk("idle reset pin", q[1], 0);
      repeat (4) @(posedge clk);
      rd(`SFC_ADDR_STATUS);
      chk("recovering", q[2:0], 3'h5);
      idle;
      test_done;
   end
endmodule // testbench
